/* File: pkg/cvms_cfg.svh */
// Purpose: constants of the cell voltage measurement sequencer
// Assumes: byte addresses on a 32-bit classic Wishbone bus
// Notes: definitions only
`ifndef CVMS_CFG_SVH
`define CVMS_CFG_SVH
// ****************
// register offsets
// ****************
`define CVMS_ADR_CTRL 10'h000
`define CVMS_ADR_CELL_MAP 10'h004
`define CVMS_ADR_AUX_EN 10'h008
`define CVMS_ADR_UV_THR 10'h00c
`define CVMS_ADR_OFFSET 10'h010
`define CVMS_ADR_GAIN 10'h014
`define CVMS_ADR_SUV_DLY 10'h018
`define CVMS_ADR_STATUS 10'h01c
`define CVMS_ADR_UV_FLAGS 10'h020
`define CVMS_ADR_MV_BASE 10'h040
`define CVMS_ADR_CUR_BASE 10'h080
`define CVMS_ADR_RAW_BASE 10'h100
// ****************
// field positions
// ****************
`define CVMS_CTRL_EN 0
`define CVMS_CTRL_FAST 1
`define CVMS_CTRL_IDLE_LSB 8
`define CVMS_STAT_ALERT 8
`define CVMS_STAT_FAULT 9
// ****************
// reset values
// ****************
`define CVMS_RST_CELL_MAP 16'hffff
`define CVMS_RST_UV_THR 16'h09c4
`define CVMS_RST_GAIN 16'h0100
`define CVMS_RST_SUV_DLY 16'h03e8
// ****************
// loop shape and timing
// ****************
`define CVMS_CELLS 16
`define CVMS_AUX_SRC 9
`define CVMS_AUX_SLOTS 3
`define CVMS_BASE_SLOTS 18
`define CVMS_ROT 3
`define CVMS_SEL_PS 5'h10
`define CVMS_SEL_IN 5'h13
`define CVMS_SEL_AUX 5'h16
`define CVMS_CLK_MHZ 200
`define CVMS_SLOT_US 3000
`define CVMS_MS_US 1000
`define CVMS_SLOT_CYC (`CVMS_SLOT_US * `CVMS_CLK_MHZ)
`define CVMS_MS_CYC (`CVMS_MS_US * `CVMS_CLK_MHZ)
`endif

/* File: pkg/cvms_pkg.sv */
// Purpose: types of the cell voltage measurement sequencer
// Assumes: constants live in cvms_cfg.svh
// Notes: state structs are registered whole
package cvms_pkg;
  typedef enum logic [1:0] {CVMS_IDLE, CVMS_CONV, CVMS_HOLD, CVMS_FILL} cvms_state_t;

  typedef struct packed {
    logic [23:0] slot_cnt;
    logic [23:0] ms_cnt;
    logic slot_end;
    logic ms_tick;
  } cvms_tmr_t;

  typedef struct packed {
    cvms_state_t st;
    logic enable;
    logic fast;
    logic [7:0] idle_n;
    logic [15:0] cell_map;
    logic [8:0] aux_en;
    logic [15:0] uv_thr;
    logic [23:0] offs;
    logic [15:0] gain;
    logic [15:0] suv_dly;
    logic [4:0] slot;
    logic [4:0] sel;
    logic [1:0] ps_rot;
    logic [1:0] in_rot;
    logic [3:0] aux_ptr;
    logic [7:0] idle_cnt;
    logic [23:0] pend_raw;
    logic [15:0] pend_cur;
    logic pend_ok;
    logic [15:0][15:0] mv;
    logic [15:0][15:0] cur;
    logic [31:0][31:0] raw;
    logic [15:0] loops;
    logic [15:0] uv_flags;
    logic c1_low;
    logic suv_alert;
    logic suv_fault;
    logic [15:0] suv_ms;
    logic ack;
    logic [31:0] dat;
    logic start;
    logic loop_done;
  } cvms_state_reg_t;
endpackage : cvms_pkg

/* File: logic/cvms_slot_timer.sv */
// Purpose: slot clock and millisecond tick of the sequencer
// Assumes: run_i low resets the slot phase
// Notes: fast_i halves the slot
`timescale 1ns/10ps
`include "cvms_cfg.svh"
module cvms_slot_timer #(
  parameter int SLOT_CYC = `CVMS_SLOT_CYC,
  parameter int MS_CYC = `CVMS_MS_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic fast_i,
  output logic slot_end_o,
  output logic ms_tick_o
);
  cvms_pkg::cvms_tmr_t t_reg;
  cvms_pkg::cvms_tmr_t t_next;
  logic [23:0] limit;

  always_comb begin
    t_next = t_reg;
    limit = fast_i ? 24'(SLOT_CYC / 2) : 24'(SLOT_CYC);
    t_next.slot_end = 1'b0;
    t_next.ms_tick = 1'b0;
    if (!run_i) begin
      t_next.slot_cnt = 24'h000000;
    end else if (t_reg.slot_cnt >= limit - 24'h000001) begin
      t_next.slot_cnt = 24'h000000;
      t_next.slot_end = 1'b1;
    end else begin
      t_next.slot_cnt = t_reg.slot_cnt + 24'h000001;
    end
    // free running so delay counts are independent of the loop
    if (t_reg.ms_cnt == 24'(MS_CYC - 1)) begin
      t_next.ms_cnt = 24'h000000;
      t_next.ms_tick = 1'b1;
    end else begin
      t_next.ms_cnt = t_reg.ms_cnt + 24'h000001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end

  assign slot_end_o = t_reg.slot_end;
  assign ms_tick_o = t_reg.ms_tick;
endmodule : cvms_slot_timer

/* File: logic/cvms_sequencer.sv */
// Purpose: measurement loop scheduler and result reporting of a battery monitor
// Assumes: converter handshake and current sample are on clk_i
// Notes: Wishbone classic slave, one wait state per access
// Operation
// - one converter is multiplexed over cells, thermistors, pack pins, regulator and ground
// - each cell result is a neighbouring-pin differential, three to sixteen series
// - corrected cell results published as 16-bit millivolt values
// - uncorrected 24-bit converter output readable in a 32-bit word
// - sixteen cells first, then pack-side, internal, up to three aux slots
// - pack-side and internal slots rotate, full set every three loops
// - loop holds 18 slots plus one per enabled aux source, at most 21
// - slot lasts 3 ms, or 1.5 ms with fast setting
// - configured idle slots are appended after the measurement slots
// - map flags real cells; undervoltage checks skip other inputs
// - every cell input reported in millivolt and raw form
// - link inputs report voltage with synchronised current
// - faulty sleep cell 1 reading may alert but not fault within delay
// - current sampled with each cell slot and stored paired
// - aux slots may use nine general analog input pins
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/10ps
`include "cvms_cfg.svh"
module cvms_sequencer #(
  parameter int SLOT_CYC = `CVMS_SLOT_CYC,
  parameter int MS_CYC = `CVMS_MS_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic adc_start_o,
  output logic [4:0] adc_sel_o,
  input wire logic adc_done_i,
  input wire logic [23:0] adc_raw_i,
  input wire logic [15:0] cur_i,
  input wire logic sleep_i,
  output logic [15:0] cell_uv_o,
  output logic suv_alert_o,
  output logic suv_fault_o,
  output logic loop_done_o
);
  cvms_pkg::cvms_state_reg_t s_reg;
  cvms_pkg::cvms_state_reg_t s_next;
  logic slot_end;
  logic ms_tick;
  logic [1:0] naux;
  logic [4:0] last_slot;
  logic [31:0] rd;
  logic [9:0] badr;

  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    q = o;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) q[b*8 +: 8] = d[b*8 +: 8];
    end
    return q;
  endfunction : wmask

  function automatic logic [3:0] aux_next(input logic [8:0] en, input logic [3:0] p);
    logic [3:0] q;
    logic [4:0] k;
    logic found;
    q = p;
    found = 1'b0;
    for (int i = 0; i < `CVMS_AUX_SRC; i++) begin
      k = 5'(p) + 5'(i);
      if (k >= 5'(`CVMS_AUX_SRC)) k = k - 5'(`CVMS_AUX_SRC);
      if (!found && en[k[3:0]]) begin
        q = k[3:0];
        found = 1'b1;
      end
    end
    return q;
  endfunction : aux_next

  function automatic logic [15:0] to_mv(input logic [23:0] raw, input logic [23:0] off, input logic [15:0] g);
    logic signed [24:0] d;
    logic signed [41:0] p;
    d = $signed({raw[23], raw}) - $signed({off[23], off});
    p = d * $signed({1'b0, g});
    return p[31:16];
  endfunction : to_mv

  cvms_slot_timer #(.SLOT_CYC(SLOT_CYC), .MS_CYC(MS_CYC)) u_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(s_reg.st != cvms_pkg::CVMS_IDLE),
    .fast_i(s_reg.fast),
    .slot_end_o(slot_end),
    .ms_tick_o(ms_tick)
  );

  always_comb begin
    naux = 2'h0;
    for (int i = 0; i < `CVMS_AUX_SRC; i++) begin
      if (s_reg.aux_en[i] && naux != 2'(`CVMS_AUX_SLOTS)) naux = naux + 2'h1;
    end
    last_slot = 5'(`CVMS_BASE_SLOTS - 1) + 5'(naux);
  end

  // ****************
  // register read mux
  // ****************
  assign badr = {wb_adr_i[9:2], 2'b00};
  always_comb begin
    rd = 32'h00000000;
    case (badr)
      `CVMS_ADR_CTRL: begin
        rd[`CVMS_CTRL_EN] = s_reg.enable;
        rd[`CVMS_CTRL_FAST] = s_reg.fast;
        rd[`CVMS_CTRL_IDLE_LSB +: 8] = s_reg.idle_n;
      end
      `CVMS_ADR_CELL_MAP: rd[15:0] = s_reg.cell_map;
      `CVMS_ADR_AUX_EN: rd[8:0] = s_reg.aux_en;
      `CVMS_ADR_UV_THR: rd[15:0] = s_reg.uv_thr;
      `CVMS_ADR_OFFSET: rd[23:0] = s_reg.offs;
      `CVMS_ADR_GAIN: rd[15:0] = s_reg.gain;
      `CVMS_ADR_SUV_DLY: rd[15:0] = s_reg.suv_dly;
      `CVMS_ADR_STATUS: rd = {s_reg.loops, 6'h00, s_reg.suv_fault, s_reg.suv_alert, 1'b0, 2'(s_reg.st), s_reg.slot};
      `CVMS_ADR_UV_FLAGS: rd[15:0] = s_reg.uv_flags;
      default: begin
        if (badr[9:6] == `CVMS_ADR_MV_BASE >> 6) begin
          rd = {{16{s_reg.mv[badr[5:2]][15]}}, s_reg.mv[badr[5:2]]};
        end else if (badr[9:6] == `CVMS_ADR_CUR_BASE >> 6) begin
          rd = {{16{s_reg.cur[badr[5:2]][15]}}, s_reg.cur[badr[5:2]]};
        end else if (badr[9:7] == `CVMS_ADR_RAW_BASE >> 7) begin
          rd = s_reg.raw[badr[6:2]];
        end
      end
    endcase
  end

  // ****************
  // next state
  // ****************
  always_comb begin
    logic [31:0] w;
    logic got;
    logic [23:0] praw;
    logic [15:0] pcur;
    logic [15:0] mvv;
    logic launch;
    logic [3:0] a;
    w = 32'h00000000;
    got = 1'b0;
    praw = s_reg.pend_raw;
    pcur = s_reg.pend_cur;
    mvv = 16'h0000;
    launch = 1'b0;
    a = 4'h0;
    s_next = s_reg;
    s_next.ack = 1'b0;
    s_next.start = 1'b0;
    s_next.loop_done = 1'b0;
    if (wb_cyc_i && wb_stb_i && !s_reg.ack) begin
      s_next.ack = 1'b1;
      s_next.dat = rd;
      if (wb_we_i) begin
        // the read mux already holds the old word of every writable register
        w = wmask(rd, wb_dat_i, wb_sel_i);
        case (badr)
          `CVMS_ADR_CTRL: begin
            s_next.enable = w[`CVMS_CTRL_EN];
            s_next.fast = w[`CVMS_CTRL_FAST];
            s_next.idle_n = w[`CVMS_CTRL_IDLE_LSB +: 8];
          end
          `CVMS_ADR_CELL_MAP: s_next.cell_map = w[15:0];
          `CVMS_ADR_AUX_EN: s_next.aux_en = w[8:0];
          `CVMS_ADR_UV_THR: s_next.uv_thr = w[15:0];
          `CVMS_ADR_OFFSET: s_next.offs = w[23:0];
          `CVMS_ADR_GAIN: s_next.gain = w[15:0];
          `CVMS_ADR_SUV_DLY: s_next.suv_dly = w[15:0];
          `CVMS_ADR_STATUS: begin
            // write one to clear; hardware sets below override
            if (wb_sel_i[1] && wb_dat_i[`CVMS_STAT_ALERT]) s_next.suv_alert = 1'b0;
            if (wb_sel_i[1] && wb_dat_i[`CVMS_STAT_FAULT]) s_next.suv_fault = 1'b0;
          end
          default: ;
        endcase
      end
    end
    // sleep undervoltage: a single bad reading holds until the next cell 1 reading and faults if that outlasts the delay
    if (!s_reg.c1_low) begin
      s_next.suv_ms = 16'h0000;
    end else if (ms_tick && s_reg.suv_ms != 16'hffff) begin
      s_next.suv_ms = s_reg.suv_ms + 16'h0001;
    end
    if (s_reg.c1_low && s_reg.suv_ms >= s_reg.suv_dly) s_next.suv_fault = 1'b1;
    if (s_reg.st == cvms_pkg::CVMS_CONV && adc_done_i) begin
      got = 1'b1;
      praw = adc_raw_i;
      pcur = cur_i;
      s_next.pend_raw = praw;
      s_next.pend_cur = pcur;
      s_next.pend_ok = 1'b1;
      s_next.st = cvms_pkg::CVMS_HOLD;
    end
    case (s_reg.st)
      cvms_pkg::CVMS_IDLE: begin
        if (s_reg.enable) begin
          launch = 1'b1;
          s_next.slot = 5'h00;
        end
      end
      cvms_pkg::CVMS_CONV, cvms_pkg::CVMS_HOLD: begin
        if (slot_end) begin
          if (s_reg.pend_ok || got) begin
            s_next.raw[s_reg.sel] = {{8{praw[23]}}, praw};
            if (s_reg.sel < 5'(`CVMS_CELLS)) begin
              mvv = to_mv(praw, s_reg.offs, s_reg.gain);
              s_next.mv[s_reg.sel[3:0]] = mvv;
              s_next.cur[s_reg.sel[3:0]] = pcur;
              s_next.uv_flags[s_reg.sel[3:0]] = s_reg.cell_map[s_reg.sel[3:0]] && $signed(mvv) < $signed(s_reg.uv_thr);
              if (s_reg.sel == 5'h00) begin
                // a good or awake reading ends the episode, else the fault re-arms forever
                s_next.c1_low = sleep_i && ($signed(mvv) < $signed(s_reg.uv_thr));
                if (sleep_i && ($signed(mvv) < $signed(s_reg.uv_thr))) s_next.suv_alert = 1'b1;
              end
            end
          end
          s_next.pend_ok = 1'b0;
          if (!s_reg.enable) begin
            s_next.st = cvms_pkg::CVMS_IDLE;
          end else if (s_reg.slot < last_slot) begin
            launch = 1'b1;
            s_next.slot = s_reg.slot + 5'h01;
          end else if (s_reg.idle_n != 8'h00) begin
            s_next.st = cvms_pkg::CVMS_FILL;
            s_next.idle_cnt = s_reg.idle_n;
          end else begin
            launch = 1'b1;
            s_next.slot = 5'h00;
            s_next.loop_done = 1'b1;
          end
        end
      end
      cvms_pkg::CVMS_FILL: begin
        if (slot_end) begin
          s_next.idle_cnt = s_reg.idle_cnt - 8'h01;
          if (!s_reg.enable) begin
            s_next.st = cvms_pkg::CVMS_IDLE;
          end else if (s_reg.idle_cnt == 8'h01) begin
            launch = 1'b1;
            s_next.slot = 5'h00;
            s_next.loop_done = 1'b1;
          end
        end
      end
      default: s_next.st = cvms_pkg::CVMS_IDLE;
    endcase
    if (s_next.loop_done) begin
      s_next.loops = s_reg.loops + 16'h0001;
      s_next.ps_rot = s_reg.ps_rot == 2'(`CVMS_ROT - 1) ? 2'h0 : s_reg.ps_rot + 2'h1;
      s_next.in_rot = s_reg.in_rot == 2'(`CVMS_ROT - 1) ? 2'h0 : s_reg.in_rot + 2'h1;
    end
    if (launch) begin
      s_next.st = cvms_pkg::CVMS_CONV;
      s_next.start = 1'b1;
      s_next.pend_ok = 1'b0;
      if (s_next.slot < 5'(`CVMS_CELLS)) begin
        s_next.sel = s_next.slot;
      end else if (s_next.slot == 5'(`CVMS_CELLS)) begin
        s_next.sel = `CVMS_SEL_PS + 5'(s_next.ps_rot);
      end else if (s_next.slot == 5'(`CVMS_CELLS + 1)) begin
        s_next.sel = `CVMS_SEL_IN + 5'(s_next.in_rot);
      end else begin
        a = aux_next(s_reg.aux_en, s_reg.aux_ptr);
        s_next.sel = `CVMS_SEL_AUX + 5'(a);
        s_next.aux_ptr = a == 4'(`CVMS_AUX_SRC - 1) ? 4'h0 : a + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.cell_map <= `CVMS_RST_CELL_MAP;
      s_reg.uv_thr <= `CVMS_RST_UV_THR;
      s_reg.gain <= `CVMS_RST_GAIN;
      s_reg.suv_dly <= `CVMS_RST_SUV_DLY;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = s_reg.dat;
  assign adc_start_o = s_reg.start;
  assign adc_sel_o = s_reg.sel;
  assign cell_uv_o = s_reg.uv_flags;
  assign suv_alert_o = s_reg.suv_alert;
  assign suv_fault_o = s_reg.suv_fault;
  assign loop_done_o = s_reg.loop_done;

  // ****************
  // checks
  // ****************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_launch;
    adc_start_o;
  endsequence
  sequence s_quiet;
    !adc_start_o [*2];
  endsequence

  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  AST_CELL_ORDER: assert property (s_launch and s_reg.slot < 5'h10 |-> adc_sel_o == s_reg.slot)
    else $error("cell slot selects wrong input");
  AST_PS_ROT: assert property (s_launch and s_reg.slot == 5'h10 |-> adc_sel_o == 5'h10 + 5'(s_reg.ps_rot))
    else $error("pack-side slot source wrong");
  AST_ROT_STEP: assert property (loop_done_o |-> s_reg.ps_rot != $past(s_reg.ps_rot))
    else $error("pack-side rotation did not advance");
  AST_LOOP_LEN: assert property (loop_done_o && $past(s_reg.st) != cvms_pkg::CVMS_FILL |->
    $past(s_reg.slot) == $past(last_slot)) else $error("loop length wrong");
  AST_SLOT_GAP: assert property (s_launch |=> s_quiet) else $error("slots too close");
  AST_IDLE_FILL: assert property (s_reg.st == cvms_pkg::CVMS_FILL |-> !adc_start_o)
    else $error("conversion during idle slot");
  AST_UV_MAP: assert property (slot_end && s_reg.st == cvms_pkg::CVMS_HOLD && s_reg.sel < 5'h10 &&
    !s_reg.cell_map[s_reg.sel[3:0]] |=> !cell_uv_o[$past(s_reg.sel[3:0])]) else $error("uv on unused input");
  AST_ATOMIC: assert property (!slot_end |=> $stable(s_reg.mv) && $stable(s_reg.cur))
    else $error("result changed mid slot");
  AST_PAIR: assert property (s_reg.st == cvms_pkg::CVMS_CONV && adc_done_i |=> s_reg.pend_cur == $past(cur_i))
    else $error("current not paired");
  AST_SUV: assert property ($rose(suv_fault_o) |-> $past(s_reg.c1_low) && $past(s_reg.suv_ms) >= $past(s_reg.suv_dly))
    else $error("fault without persisting low reading");
endmodule : cvms_sequencer

/* File: testbench/cvms_adc_model.sv */
// Purpose: converter model answering the sequencer's start pulses
// Assumes: one conversion pending at a time; a new start restarts it
// Notes: dly_i beyond the slot length means no answer in that slot
`timescale 1ns/10ps
module cvms_adc_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [4:0] sel_i,
  input wire logic low_i,
  input wire logic [5:0] dly_i,
  output logic done_o,
  output logic [23:0] raw_o,
  output logic [15:0] cur_o
);
  // ************
  // conversion
  // ************
  logic busy;
  logic [5:0] cnt;
  logic [4:0] src;

  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      busy <= 1'b0;
      raw_o <= 24'h000000;
      cur_o <= 16'h0000;
    end else if (start_i) begin
      busy <= 1'b1;
      cnt <= dly_i;
      src <= sel_i;
    end else if (busy && cnt == 6'h00) begin
      busy <= 1'b0;
      done_o <= 1'b1;
      if (src < 5'h10) begin
        raw_o <= (low_i && src == 5'h00) ? 24'h000800 : 24'h0bb800 + {7'h00, src, 12'h000};
      end else begin
        raw_o <= {3'h0, src, 16'h0000};
      end
      cur_o <= 16'h0300 + {11'h000, src};
    end else begin
      cnt <= cnt - 6'h01;
      // data lines hold only in the done cycle
      if (done_o) begin
        raw_o <= ~raw_o;
        cur_o <= ~cur_o;
      end
    end
  end
endmodule : cvms_adc_model

/* File: testbench/testbench.sv */
// Purpose: self-checking bench of the measurement sequencer
// Assumes: short slot and millisecond counts set by parameter
// Notes: register access over classic Wishbone, one request at a time
`timescale 1ns/10ps
`include "cvms_cfg.svh"
module testbench;
  localparam int SLOT = 40;
  logic clk_i, rst_i, cyc, stb, we, sleep, low;
  logic [9:0] adr;
  logic [31:0] wdat, rdat, q;
  logic ack, start, done, ld, alert, fault;
  logic [4:0] sel;
  logic [23:0] raw;
  logic [15:0] cur, cell_uv;
  logic [5:0] dly;
  logic [4:0] sq[$];
  int bad_count, comparisons, cycles, n, pm, im;

  cvms_sequencer #(.SLOT_CYC(SLOT), .MS_CYC(10)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .adc_start_o(start), .adc_sel_o(sel), .adc_done_i(done), .adc_raw_i(raw),
    .cur_i(cur), .sleep_i(sleep), .cell_uv_o(cell_uv), .suv_alert_o(alert), .suv_fault_o(fault),
    .loop_done_o(ld));
  cvms_adc_model u_adc (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .sel_i(sel), .low_i(low),
    .dly_i(dly), .done_o(done), .raw_o(raw), .cur_o(cur));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ************
  // helpers
  // ************
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 100);
    if (ack !== 1'b1) chk(ack, 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    chk(q, exp);
  endtask : rd

  task automatic wait_ld(input int loops);
    repeat (loops) begin
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (ld !== 1'b1 && n < 2000);
      if (ld !== 1'b1) chk(ld, 1'b1);
    end
  endtask : wait_ld

  function automatic logic [31:0] exp_mv(input int i);
    longint r;
    r = ((longint'(32'h0bb800) + i * 4096 - 64) * 256) >>> 16;
    return {{16{r[15]}}, r[15:0]};
  endfunction : exp_mv

  // restart with a new loop shape and time one loop between two loop_done pulses
  task automatic run_cfg(input logic [8:0] aux, input logic [7:0] idle, input logic f, input logic [5:0] d,
                         input int slots);
    wr(`CVMS_ADR_CTRL, 32'h00000000);
    repeat (SLOT + 2) @(posedge clk_i);
    dly <= d;
    wr(`CVMS_ADR_AUX_EN, {23'h000000, aux});
    wr(`CVMS_ADR_CTRL, {16'h0000, idle, 6'h00, f, 1'b1});
    wait_ld(2);
    chk(n, (slots + idle) * (f ? SLOT / 2 : SLOT));
  endtask : run_cfg

  always @(posedge clk_i) begin
    cycles++;
    if (start === 1'b1) begin
      sq.push_back(sel);
    end
    // ceiling well above the roughly 22000 cycles the sequence needs
    if (cycles == 60000) begin
      bad_count++;
      end_sim();
    end
  end

  // ************
  // sequence
  // ************
  initial begin
    rst_i <= 1'b1;
    {cyc, stb, we, sleep, low} <= 5'h00;
    adr <= 10'h000;
    wdat <= 32'h00000000;
    dly <= 6'h03;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`CVMS_ADR_CTRL, 32'h00000000);
    rd(`CVMS_ADR_CELL_MAP, 32'h0000ffff);
    rd(`CVMS_ADR_UV_THR, 32'h000009c4);
    rd(`CVMS_ADR_GAIN, 32'h00000100);
    rd(`CVMS_ADR_SUV_DLY, 32'h000003e8);
    rd(`CVMS_ADR_STATUS, 32'h00000000);
    wr(10'h3fc, 32'hdeadbeef);
    rd(10'h3fc, 32'h00000000);
    wr(`CVMS_ADR_OFFSET, 32'h00000040);
    run_cfg(9'h000, 8'h00, 1'b0, 6'h03, 18);
    run_cfg(9'h001, 8'h00, 1'b0, 6'h25, 19);
    run_cfg(9'h003, 8'h00, 1'b1, 6'h0f, 20);
    run_cfg(9'h1ff, 8'h00, 1'b0, 6'h03, 21);
    run_cfg(9'h00f, 8'h02, 1'b0, 6'h03, 21);
    repeat (5) @(posedge clk_i);
    sq.delete();
    wait_ld(4);
    repeat (5) @(posedge clk_i);
    // idle slots start nothing: 20 + 3 * 21 + 1 starts
    chk(sq.size(), 84);
    pm = 0;
    im = 0;
    for (int k = 0; k < 3; k++) begin
      for (int j = 0; j < 16; j++) begin
        chk(sq[20 + 21 * k + j], j);
      end
      pm = pm | (1 << (sq[36 + 21 * k] - 16));
      im = im | (1 << (sq[37 + 21 * k] - 19));
    end
    chk(pm, 7);
    chk(im, 7);
    for (int j = 0; j < 8; j++) begin
      chk(sq[38 + 21 * ((j + 1) / 3) + (j + 1) % 3], 22 + (sq[38 + 21 * (j / 3) + j % 3] - 21) % 4);
    end
    for (int i = 0; i < 16; i++) begin
      rd(10'(`CVMS_ADR_MV_BASE + 4 * i), exp_mv(i));
      rd(10'(`CVMS_ADR_CUR_BASE + 4 * i), 32'h00000300 + i);
      rd(10'(`CVMS_ADR_RAW_BASE + 4 * i), 32'h000bb800 + i * 4096);
    end
    for (int i = 16; i < 26; i++) begin
      rd(10'(`CVMS_ADR_RAW_BASE + 4 * i), i << 16);
    end
    wr(`CVMS_ADR_UV_THR, 32'h00000c38);
    wr(`CVMS_ADR_CELL_MAP, 32'h0000ff7b);
    wait_ld(2);
    chk(cell_uv, 16'h017b);
    rd(`CVMS_ADR_UV_FLAGS, 32'h0000017b);
    wr(`CVMS_ADR_UV_THR, 32'h000009c4);
    wr(`CVMS_ADR_CELL_MAP, 32'h0000ffff);
    // converter never answers: old results must stand
    // one clean loop refreshes every flag under the restored threshold
    wait_ld(1);
    repeat (8) @(posedge clk_i);
    dly <= 6'h3f;
    low <= 1'b1;
    wait_ld(2);
    rd(`CVMS_ADR_MV_BASE, exp_mv(0));
    chk(cell_uv, 16'h0000);
    dly <= 6'h03;
    sleep <= 1'b1;
    wait_ld(2);
    chk(alert, 1'b1);
    chk(fault, 1'b0);
    chk(cell_uv, 16'h0001);
    rd(`CVMS_ADR_MV_BASE, 32'h00000007);
    wr(`CVMS_ADR_SUV_DLY, 32'h00000002);
    wait_ld(2);
    chk(fault, 1'b1);
    low <= 1'b0;
    sleep <= 1'b0;
    wait_ld(2);
    rd(`CVMS_ADR_MV_BASE, exp_mv(0));
    wr(`CVMS_ADR_STATUS, 32'h00000300);
    xfer(1'b0, `CVMS_ADR_STATUS, 32'h00000000);
    chk(q & 32'h00000300, 32'h00000000);
    chk({alert, fault}, 2'h0);
    end_sim();
  end
endmodule : testbench
